// *** rtl/wdtl_pkg.sv ***
// constants and carrier types for the lfsr-cleared watchdog timer
package wdtl_pkg;
    // register byte addresses
    localparam logic [31:0] ADDR_LOAD  = 32'hFFFF0360;
    localparam logic [31:0] ADDR_VALUE = 32'hFFFF0364;
    localparam logic [31:0] ADDR_CTRL  = 32'hFFFF0368;
    localparam logic [31:0] ADDR_CLEAR = 32'hFFFF036C;
    // reset values
    localparam logic [15:0] LOAD_RST   = 16'h0000;
    localparam logic [15:0] VALUE_RST  = 16'hFFFF;
    localparam logic [8:0]  CTRL_RST   = 9'h000;
    localparam logic [7:0]  LFSR_RST   = 8'h00;
    // control field positions and implemented-bit mask
    localparam int          CB_UP      = 8;
    localparam int          CB_EN      = 7;
    localparam int          CB_PER     = 6;
    localparam int          CB_WD      = 5;
    localparam int          CB_SEC     = 4;
    localparam int          CB_PS_HI   = 3;
    localparam int          CB_PS_LO   = 2;
    localparam int          CB_IRQ     = 1;
    localparam logic [8:0]  CTRL_MASK  = 9'h1FE;
    // prescale codes and divide-minus-one counts
    localparam logic [1:0]  PS_DIV16   = 2'h1;
    localparam logic [1:0]  PS_DIV256  = 2'h2;
    localparam logic [7:0]  PS_TOP1    = 8'h00;
    localparam logic [7:0]  PS_TOP16   = 8'h0F;
    localparam logic [7:0]  PS_TOP256  = 8'hFF;
    // source clock derived from the system clock
    localparam int          SYS_CLK_HZ = 100_000_000;
    localparam int          SRC_CLK_HZ = 32_768;
    localparam logic [11:0] SRC_TOP    = 12'(SYS_CLK_HZ / SRC_CLK_HZ - 1);
    // galois feedback for x^8 + x^6 + x^5 + x + 1
    localparam logic [7:0]  LFSR_TAPS  = 8'h63;
    localparam logic [7:0]  KEY_ZERO   = 8'h00;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] CNT_FULL   = 16'hFFFF;
    // axi responses
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } wdtl_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } wdtl_axi_rsp_t;
endpackage : wdtl_pkg

// *** rtl/wdtl_timer.sv ***
// watchdog timer with secure lfsr clear, axi4-lite register slave
// Functional notes
// [RL1] control bit 5 enters watchdog mode
// [RL2] watchdog counts load value down to zero
// [RL3] watchdog clocked from 32 kHz source
// [RL4] divide-by-256 full load gives 512 s
// [RL5] software writes load before setting enable
// [RL6] expiry: interrupt if bit 1, else reset
// [RL7] clear write reloads counter, new period
// [RL8] load and control locked in watchdog mode
// [RL9] normal mode: general timer, scaled 32 kHz
// [RL10] prescale bits 3:2 divide 1/16/256, 11=00
// [RL11] control bit 8 selects count up
// [RL12] control bit 7 enables the timer
// [RL13] control bit 6 selects periodic mode
// [RL14] secure clear needs expected sequence value
// [RL15] expected values from 8-bit lfsr polynomial
// [RL16] seed written to clear before watchdog
// [RL17] matching write advances lfsr on reload
// [RL18] mismatch write resets immediately
// [RL19] value 0x00 always forces reset
// [RL20] lfsr state has no read path
// [RL21] normal mode clear write clears interrupt
// [RL22] value register reads count, resets 0xFFFF
// [RL23] interrupt holds until clear write
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module wdtl_timer
    import wdtl_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // register bus
    input  wire wdtl_axi_req_t axi_req,
    output wdtl_axi_rsp_t      axi_rsp,
    // system outputs
    output logic               timer_irq,
    output logic               wdt_reset_req
);

    wdtl_axi_rsp_t rsp_r;
    logic [15:0]   load_r;
    logic [15:0]   cnt_r;
    logic [8:0]    ctrl_r;
    logic [7:0]    lfsr_r;
    logic [11:0]   src_r;
    logic [7:0]    ps_r;
    logic          irq_r;
    logic          rst_req_r;
    logic          aw_held_r;
    logic          w_held_r;
    logic [31:0]   awaddr_r;
    logic [31:0]   wdata_r;
    logic [3:0]    wstrb_r;

    logic          wr_go;
    logic          wr_hit;
    logic          wr_load;
    logic          wr_ctrl;
    logic          wr_clr;
    logic [31:0]   wmask;
    logic [15:0]   load_nxt;
    logic [8:0]    ctrl_nxt;
    logic          wd_mode;
    logic          wd_enter;
    logic          secure;
    logic          key_ok;
    logic          src_tick;
    logic          step;
    logic [7:0]    ps_top;
    logic          expire;
    logic          norm_evt;
    logic          wd_clr_ok;
    logic          wd_clr_bad;
    logic [7:0]    lfsr_nxt;
    logic          rd_go;

    assign axi_rsp       = rsp_r;
    assign timer_irq     = irq_r;
    assign wdt_reset_req = rst_req_r;

    // write path: address and data accepted in either order
    assign wr_go   = aw_held_r && w_held_r && !rsp_r.bvalid;
    assign wr_hit  = awaddr_r == ADDR_LOAD || awaddr_r == ADDR_CTRL
                     || awaddr_r == ADDR_CLEAR;
    assign wr_load = wr_go && awaddr_r == ADDR_LOAD;
    assign wr_ctrl = wr_go && awaddr_r == ADDR_CTRL;
    assign wr_clr  = wr_go && awaddr_r == ADDR_CLEAR && wstrb_r[0];
    assign rd_go   = axi_req.arvalid && rsp_r.arready;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign wmask[gi*8 +: 8] = {8{wstrb_r[gi]}};
        end
    endgenerate

    assign load_nxt = (load_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
    assign ctrl_nxt = ((ctrl_r & ~wmask[8:0]) | (wdata_r[8:0] & wmask[8:0]))
                      & CTRL_MASK;

    assign wd_mode  = ctrl_r[CB_WD];
    assign secure   = ctrl_r[CB_SEC];
    assign wd_enter = wr_ctrl && !wd_mode && ctrl_nxt[CB_WD]; // [RL1]

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end
        else
        begin
            if (axi_req.awvalid && rsp_r.awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= axi_req.awaddr;
            end
            else if (wr_go)
            begin
                aw_held_r <= 1'b0;
            end
            if (axi_req.wvalid && rsp_r.wready)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= axi_req.wdata;
                wstrb_r  <= axi_req.wstrb;
            end
            else if (wr_go)
            begin
                w_held_r <= 1'b0;
            end
        end
    end

    // bus responses; one write and one read in flight
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_r <= '0;
        end
        else
        begin
            rsp_r.awready <= !aw_held_r && !(axi_req.awvalid && rsp_r.awready)
                             && !rsp_r.bvalid;
            rsp_r.wready  <= !w_held_r && !(axi_req.wvalid && rsp_r.wready)
                             && !rsp_r.bvalid;
            if (wr_go)
            begin
                rsp_r.bvalid <= 1'b1;
                rsp_r.bresp  <= wr_hit ? RESP_OKAY : RESP_SLV;
            end
            else if (axi_req.bready)
            begin
                rsp_r.bvalid <= 1'b0;
            end
            rsp_r.arready <= !rsp_r.rvalid && !rd_go;
            if (rd_go)
            begin
                rsp_r.rvalid <= 1'b1;
                rsp_r.rresp  <= RESP_OKAY;
                rsp_r.rdata  <= '0;
                case (axi_req.araddr)
                    ADDR_LOAD:  rsp_r.rdata[15:0] <= load_r;
                    ADDR_VALUE: rsp_r.rdata[15:0] <= cnt_r; // [RL22]
                    ADDR_CTRL:  rsp_r.rdata[8:0]  <= ctrl_r;
                    ADDR_CLEAR: rsp_r.rdata       <= '0; // [RL20]
                    default:    rsp_r.rresp       <= RESP_SLV;
                endcase
            end
            else if (axi_req.rready)
            begin
                rsp_r.rvalid <= 1'b0;
            end
        end
    end

    // load and control; frozen once watchdog mode is on
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_r <= LOAD_RST;
            ctrl_r <= CTRL_RST;
        end
        else if (!wd_mode) // [RL8]
        begin
            if (wr_load)
            begin
                load_r <= load_nxt;
            end
            if (wr_ctrl)
            begin
                ctrl_r <= ctrl_nxt;
            end
        end
    end

    // 32 kHz source from the system clock, then the prescaler
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_r <= '0;
        end
        else
        begin
            src_r <= src_tick ? '0 : src_r + 12'h001; // [RL3] [RL9]
        end
    end
    assign src_tick = src_r == SRC_TOP;

    always_comb
    begin
        case (ctrl_r[CB_PS_HI:CB_PS_LO]) // [RL10]
            PS_DIV16:  ps_top = PS_TOP16;
            PS_DIV256: ps_top = PS_TOP256; // [RL4]
            default:   ps_top = PS_TOP1;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ps_r <= '0;
        end
        else if (wr_ctrl || wd_enter)
        begin
            ps_r <= '0;
        end
        else if (src_tick)
        begin
            ps_r <= (ps_r >= ps_top) ? '0 : ps_r + 8'h01;
        end
    end
    assign step = src_tick && ps_r >= ps_top;

    // secure key compare; zero never matches
    assign key_ok     = wdata_r[7:0] == lfsr_r && wdata_r[7:0] != KEY_ZERO; // [RL19]
    assign wd_clr_ok  = wd_mode && wr_clr && (!secure || key_ok); // [RL14]
    assign wd_clr_bad = wd_mode && wr_clr && secure && !key_ok; // [RL18]
    assign lfsr_nxt   = {lfsr_r[6:0], 1'b0} ^ (lfsr_r[7] ? LFSR_TAPS : KEY_ZERO); // [RL15]
    // expiry taken on the step that finds the count at zero
    assign expire     = wd_mode && step && cnt_r == CNT_ZERO && !wd_clr_ok;
    assign norm_evt   = !wd_mode && ctrl_r[CB_EN] && step
                        && cnt_r == (ctrl_r[CB_UP] ? CNT_FULL : CNT_ZERO);

    // counter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= VALUE_RST;
        end
        else if (wd_enter)
        begin
            cnt_r <= load_r; // [RL2] [RL5]
        end
        else if (wd_mode)
        begin
            if (wd_clr_ok || expire)
            begin
                cnt_r <= load_r; // [RL7]
            end
            else if (step)
            begin
                cnt_r <= cnt_r - 16'h0001; // [RL2]
            end
        end
        else if (ctrl_r[CB_EN] && step) // [RL12]
        begin
            if (norm_evt)
            begin
                cnt_r <= ctrl_r[CB_PER] ? load_r // [RL13]
                         : (ctrl_r[CB_UP] ? CNT_ZERO : CNT_FULL);
            end
            else
            begin
                cnt_r <= ctrl_r[CB_UP] ? cnt_r + 16'h0001 : cnt_r - 16'h0001; // [RL11]
            end
        end
    end

    // lfsr: seeded outside watchdog mode, advanced on good clears in secure mode
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lfsr_r <= LFSR_RST;
        end
        else if (!wd_mode && wr_clr)
        begin
            lfsr_r <= wdata_r[7:0]; // [RL16]
        end
        else if (wd_clr_ok && secure)
        begin
            lfsr_r <= lfsr_nxt; // [RL17]
        end
    end

    // interrupt: a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_r <= 1'b0;
        end
        else if (norm_evt || (expire && ctrl_r[CB_IRQ]))
        begin
            irq_r <= 1'b1; // [RL6] [RL23]
        end
        else if (wr_clr)
        begin
            irq_r <= 1'b0; // [RL21]
        end
    end

    // reset request is a one-cycle pulse to the system reset logic
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_req_r <= 1'b0;
        end
        else
        begin
            rst_req_r <= (expire && !ctrl_r[CB_IRQ]) || wd_clr_bad; // [RL6] [RL18]
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_wd_entry_load: assert property (wd_enter |=> wd_mode && cnt_r == $past(load_r)) // [RL1]
        else $error("watchdog entry did not load counter");
    chk_lock_regs: assert property (wd_mode && (wr_load || wr_ctrl) // [RL8]
        |=> $stable(load_r) && $stable(ctrl_r))
        else $error("locked register changed in watchdog mode");
    chk_clear_reload: assert property (wd_clr_ok |=> cnt_r == $past(load_r)) // [RL7]
        else $error("good clear did not reload counter");
    chk_lfsr_advance: assert property (wd_clr_ok && secure // [RL17]
        |=> lfsr_r == ({$past(lfsr_r[6:0]), 1'b0}
                       ^ ($past(lfsr_r[7]) ? LFSR_TAPS : KEY_ZERO)))
        else $error("lfsr did not advance");
    chk_bad_key_rst: assert property (wd_mode && secure && wr_clr // [RL18]
        && wdata_r[7:0] != lfsr_r |=> wdt_reset_req)
        else $error("mismatched key gave no reset");
    chk_zero_key_rst: assert property (wd_mode && secure && wr_clr // [RL19]
        && wdata_r[7:0] == KEY_ZERO |=> wdt_reset_req)
        else $error("zero key gave no reset");
    // a bad key in the expiry cycle still owes its reset
    chk_expire_action: assert property (expire // [RL6]
        |=> (ctrl_r[CB_IRQ] ? timer_irq && wdt_reset_req == $past(wd_clr_bad)
                            : wdt_reset_req))
        else $error("expiry action wrong");
    chk_irq_hold: assert property (timer_irq && !wr_clr |=> timer_irq) // [RL23]
        else $error("interrupt dropped without clear");
    chk_irq_clear: assert property (timer_irq && wr_clr && !norm_evt && !expire // [RL21]
        |=> !timer_irq)
        else $error("clear write left interrupt pending");
    chk_value_read: assert property (rd_go && axi_req.araddr == ADDR_VALUE // [RL22]
        |=> axi_rsp.rvalid && axi_rsp.rdata == {16'h0000, $past(cnt_r)})
        else $error("value read returned wrong count");
    chk_step_rate: assert property (!wd_mode && !wr_ctrl && !src_tick |=> $stable(cnt_r)) // [RL9]
        else $error("counter moved off the source tick");

    cov_wd_entry: cover property (wd_enter);
    cov_secure_ok: cover property (wd_clr_ok && secure);
    cov_expire_rst: cover property (expire && !ctrl_r[CB_IRQ]);
    cov_norm_irq: cover property (norm_evt);

endmodule : wdtl_timer

// *** verification/wdtl_sys_model.sv ***
// system reset partner model for the lfsr-cleared watchdog
`timescale 1ns/10ps
module wdtl_sys_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // from the watchdog
    input  wire logic       wdt_reset_req,
    // seen by the bench
    output logic [7:0]      rst_cnt
);
    // counts high cycles, so a stretched pulse shows as extra resets
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_cnt <= 8'h00;
        else if (wdt_reset_req)
            rst_cnt <= rst_cnt + 8'h01;
    end
endmodule : wdtl_sys_model

// *** verification/watchdog_timer_lfsr_clear_tb_top.sv ***
// self-checking bench for the lfsr-cleared watchdog timer
`timescale 1ns/10ps
module watchdog_timer_lfsr_clear_tb_top
    import wdtl_pkg::*;
;
    // normal-mode cases: control word, irq after one source tick, count after one source tick
    localparam logic [31:0] MODE_TAB [7] = '{32'h1C0, 32'h1C4, 32'h1C8, 32'h1CC,
                                             32'h180, 32'h140, 32'h0C0};
    localparam logic [31:0] VAL_TAB [7]  = '{32'h5, 32'hFFFF, 32'hFFFF, 32'h5,
                                             32'h0, 32'hFFFF, 32'hFFFE};
    localparam logic        IRQ_TAB [7]  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    localparam int          CYC_MAX      = 90000;
    logic          sys_clk;
    logic          rst_n;
    wdtl_axi_req_t req;
    wdtl_axi_rsp_t rsp;
    logic          timer_irq;
    logic          wdt_reset_req;
    logic [7:0]    rst_cnt;
    logic [31:0]   rd;
    logic [1:0]    rs;
    logic [7:0]    key;
    int            n_mismatch = 0;
    int            n_compared = 0;
    int            n_cyc = 0;
    int            n;

    wdtl_timer u_dut (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .axi_req       (req),
        .axi_rsp       (rsp),
        .timer_irq     (timer_irq),
        .wdt_reset_req (wdt_reset_req)
    );
    wdtl_sys_model u_sys (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .wdt_reset_req (wdt_reset_req),
        .rst_cnt       (rst_cnt)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task end_sim;
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // hang guard, well above the longest expected run
    always @(posedge sys_clk)
    begin
        n_cyc++;
        if (n_cyc == CYC_MAX)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : cyc

    // address and data offered together, each dropped once taken
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.bready  <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        rs = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr

    task rdr(input logic [31:0] a);
        @(posedge sys_clk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (req.arvalid && rsp.arready)
                req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rdr

    task rchk(input logic [31:0] a, input logic [31:0] exp);
        rdr(a);
        chk(rd, exp);
    endtask : rchk

    task do_reset;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
    endtask : do_reset

    // bench's own key sequence, software has to track it
    function automatic logic [7:0] key_next(input logic [7:0] s);
        return {s[6:0], 1'b0} ^ (s[7] ? LFSR_TAPS : 8'h00);
    endfunction : key_next

    initial
    begin
        req   = '0;
        rst_n = 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        rchk(ADDR_LOAD, 32'h0);
        rchk(ADDR_VALUE, 32'hFFFF);
        rchk(ADDR_CTRL, 32'h0);
        rchk(ADDR_CLEAR, 32'h0);
        rdr(32'hFFFF0370);
        chk(rs, RESP_SLV);
        wr(ADDR_VALUE, 32'h0);
        chk(rs, RESP_SLV);
        wr(ADDR_LOAD, 32'h12345);
        chk(rs, RESP_OKAY);
        rchk(ADDR_LOAD, 32'h2345);
        // one source tick per case, each from a fresh reset
        for (int i = 0; i < 7; i++)
        begin
            do_reset();
            wr(ADDR_LOAD, 32'h5);
            wr(ADDR_CTRL, MODE_TAB[i]);
            cyc(3200);
            chk(timer_irq, IRQ_TAB[i]);
            rchk(ADDR_VALUE, VAL_TAB[i]);
            chk(timer_irq, IRQ_TAB[i]);
            wr(ADDR_CLEAR, 32'h0);
            cyc(2);
            chk(timer_irq, 1'b0);
        end
        // up free-run wraps to zero, then down periodic reloads at zero
        do_reset();
        wr(ADDR_CTRL, 32'h180);
        cyc(3200);
        rchk(ADDR_VALUE, 32'h0);
        wr(ADDR_CLEAR, 32'h0);
        wr(ADDR_LOAD, 32'h5);
        wr(ADDR_CTRL, 32'h0C0);
        cyc(3200);
        chk(timer_irq, 1'b1);
        rchk(ADDR_VALUE, 32'h5);
        // watchdog with interrupt option, serviced then left to expire
        do_reset();
        wr(ADDR_LOAD, 32'h2);
        wr(ADDR_CTRL, 32'h22);
        rchk(ADDR_VALUE, 32'h2);
        wr(ADDR_LOAD, 32'h7);
        wr(ADDR_CTRL, 32'h0);
        chk(rs, RESP_OKAY);
        rchk(ADDR_LOAD, 32'h2);
        rchk(ADDR_CTRL, 32'h22);
        repeat (4)
        begin
            cyc(2500);
            wr(ADDR_CLEAR, 32'h5A);
        end
        chk(timer_irq, 1'b0);
        n = 0;
        while (timer_irq !== 1'b1 && n < 9400)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk(timer_irq, 1'b1);
        chk(n >= 6090, 1'b1);
        chk(rst_cnt, 8'h00);
        // watchdog with reset option
        do_reset();
        wr(ADDR_LOAD, 32'h1);
        wr(ADDR_CTRL, 32'h20);
        n = 0;
        while (rst_cnt == 8'h00 && n < 6400)
        begin
            @(posedge sys_clk);
            n++;
        end
        cyc(3);
        chk(rst_cnt, 8'h01);
        chk(timer_irq, 1'b0);
        // secure clear: good keys, then a wrong one
        do_reset();
        wr(ADDR_CLEAR, 32'hAA);
        wr(ADDR_LOAD, 32'h100);
        wr(ADDR_CTRL, 32'h30);
        key = 8'hAA;
        repeat (3)
        begin
            wr(ADDR_CLEAR, {24'h0, key});
            key = key_next(key);
        end
        cyc(3);
        chk(rst_cnt, 8'h00);
        wr(ADDR_CLEAR, 32'h66);
        cyc(3);
        chk(rst_cnt, 8'h01);
        // zero key resets even when it matches the seed
        do_reset();
        wr(ADDR_CLEAR, 32'h0);
        wr(ADDR_LOAD, 32'h100);
        wr(ADDR_CTRL, 32'h30);
        wr(ADDR_CLEAR, 32'h0);
        cyc(3);
        chk(rst_cnt, 8'h01);
        end_sim();
    end
endmodule : watchdog_timer_lfsr_clear_tb_top
